// *** slvp_ahb.sv ***
// ahb-lite slave front end: turns bus transfers into register strobes
`timescale 1ns/100ps
module slvp_ahb
	import slvp_pkg::*;
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic hready_i,
	input wire logic [31:0] hwdata_i,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic [31:0] hrdata_o,
	output logic reg_wr_o,
	output logic reg_rd_o,
	output logic [9:0] reg_idx_o,
	output logic [7:0] reg_wdata_o,
	input wire logic [7:0] reg_rdata_i
);

	typedef struct packed {
		logic phase_wr;
		logic phase_rd;
		logic rd_done;
		logic [9:0] idx;
		logic [31:0] rdata;
	} slvp_ahb_s;

	slvp_ahb_s state_reg;
	slvp_ahb_s state_next;
	logic accept;
	logic ready;

	// reads take one wait state so hrdata comes from a flip-flop
	assign ready = !(state_reg.phase_rd && !state_reg.rd_done);
	assign accept = hsel_i && (htrans_i == HTRANS_NONSEQ) && hready_i;

	always_comb
	begin
		state_next = state_reg;
		if (ready)
		begin
			state_next.phase_wr = accept && hwrite_i;
			state_next.phase_rd = accept && !hwrite_i;
			state_next.rd_done = 1'h0;
			if (accept)
				state_next.idx = haddr_i[11:2];
		end
		else
		begin
			// read side effects happen exactly once, here
			state_next.rd_done = 1'h1;
			state_next.rdata = {24'h000000, reg_rdata_i};
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign hreadyout_o = ready;
	assign hresp_o = HRESP_OKAY;
	assign hrdata_o = state_reg.rdata;
	assign reg_wr_o = state_reg.phase_wr;
	assign reg_rd_o = state_reg.phase_rd && !state_reg.rd_done;
	assign reg_idx_o = state_reg.idx;
	assign reg_wdata_o = hwdata_i[7:0];

endmodule

// *** slvp_ext_proc.sv ***
// external processor driving the slave port strobes and data pins
`timescale 1ns/100ps
module slvp_ext_proc
	import slvp_pkg::*;
(
	input wire logic clk_i,
	input wire logic [7:0] dev_pd_i,
	input wire logic [7:0] dev_oe_i,
	output logic [7:0] pins_o,
	output logic [2:0] strobes_o
);
	logic [7:0] drv_val = 8'h00;
	logic drv_on = 1'b0;
	// undriven pins show the inverse byte so no stale value passes
	assign pins_o = dev_oe_i & dev_pd_i
		| ~dev_oe_i & (drv_on ? drv_val : ~drv_val);
	initial
	begin
		strobes_o = 3'h7;
	end
	// one transfer, no shared clock; n sets the hold, 1 is the minimum
	task automatic xfer(input int pin, input logic [7:0] d, input int n,
		output logic [7:0] q);
		strobes_o <= (pin == PIN_RD) ? 3'h2 : 3'h1;
		drv_val <= d;
		drv_on <= pin == PIN_WR;
		repeat (n) @(posedge clk_i);
		q = pins_o;
		strobes_o <= 3'h3;
		repeat (n) @(posedge clk_i);
		strobes_o <= 3'h7;
		drv_on <= 1'b0;
		repeat (n) @(posedge clk_i);
	endtask
endmodule

// *** slvp_pkg.sv ***
// constants, register map and state layout of the parallel slave port
package slvp_pkg;

	// register indices; byte address on the bus is four times the index
	localparam logic [9:0] IDX_DATA_PORT = 10'h008;
	localparam logic [9:0] IDX_CTRL_PINS = 10'h009;
	localparam logic [9:0] IDX_INT_FLAGS = 10'h00C;
	localparam logic [9:0] IDX_DATA_DIR = 10'h088;
	localparam logic [9:0] IDX_STATUS_CTRL = 10'h089;
	localparam logic [9:0] IDX_INT_ENABLES = 10'h08C;

	// field positions in slave_port_status_ctrl
	localparam int BIT_IN_FULL = 7;
	localparam int BIT_OUT_FULL = 6;
	localparam int BIT_OVERRUN = 5;
	localparam int BIT_MODE = 4;
	// slave_port_irq_flag / slave_port_irq_enable position
	localparam int BIT_IRQ = 7;

	// control pin roles while in slave mode
	localparam int PIN_RD = 0;
	localparam int PIN_WR = 1;
	localparam int PIN_CS = 2;

	// synchroniser: {data pins, control pins}; strobes idle high
	localparam int SYNC_W = 11;
	localparam logic [10:0] SYNC_RST = 11'h007;

	// reset values
	localparam logic [7:0] STATUS_CTRL_RST = 8'h07;
	localparam logic [7:0] DATA_DIR_RST = 8'hFF;
	localparam logic [7:0] DATA_LATCH_RST = 8'h00;
	localparam logic [2:0] CTRL_OUT_RST = 3'h0;

	// bus constants
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'h0;

	typedef struct packed {
		logic [7:0] out_latch;
		logic [7:0] in_latch;
		logic in_full;
		logic out_full;
		logic overrun;
		logic mode;
		logic [2:0] cp_dir;
		logic [2:0] cp_out;
		logic [7:0] d_dir;
		logic irq_flag;
		logic irq_en;
		logic rd_prev;
		logic wr_prev;
		logic cs_prev;
	} slvp_state_s;

	localparam slvp_state_s STATE_RST = '{
		out_latch: DATA_LATCH_RST,
		in_latch: DATA_LATCH_RST,
		in_full: STATUS_CTRL_RST[BIT_IN_FULL],
		out_full: STATUS_CTRL_RST[BIT_OUT_FULL],
		overrun: STATUS_CTRL_RST[BIT_OVERRUN],
		mode: STATUS_CTRL_RST[BIT_MODE],
		cp_dir: STATUS_CTRL_RST[2:0],
		cp_out: CTRL_OUT_RST,
		d_dir: DATA_DIR_RST,
		irq_flag: 1'h0,
		irq_en: 1'h0,
		rd_prev: SYNC_RST[PIN_RD],
		wr_prev: SYNC_RST[PIN_WR],
		cs_prev: SYNC_RST[PIN_CS]
	};

endpackage

// *** slvp_sync.sv ***
// two flip-flop synchroniser for a group of level inputs
`timescale 1ns/100ps
module slvp_sync
	import slvp_pkg::*;
#(
	parameter int W = SYNC_W,
	parameter logic [W-1:0] RST_VAL = '0
)
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} slvp_sync_s;

	slvp_sync_s state_reg;
	slvp_sync_s state_next;

	// first stage feeds only the second stage
	always_comb
	begin
		state_next = state_reg;
		state_next.meta = d_i;
		state_next.stable = state_reg.meta;
	end

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			state_reg <= '{meta: RST_VAL, stable: RST_VAL};
		else
			state_reg <= state_next;
	end

	assign q_o = state_reg.stable;

endmodule

// *** slvp_top.sv ***
// parallel slave port with its register file on an ahb-lite bus
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/100ps

// Summary of operation
// R1: Setting the slave port enable turns the data port into an 8-bit port.
// R2: The external processor reads and writes at any time, no shared clock.
// R3: In slave mode the control pins are read strobe, write strobe, select.
// R4: Software sets the three control pin directions to input before use.
// R5: One address, two latches: CPU writes the output, reads the input latch.
// R6: In slave mode the data direction register is ignored; strobes decide.
// R7: Read-only input full flag (bit 7) sets on external write, clears on read.
// R8: Output full flag (bit 6) sets on CPU write, clears on external read.
// R9: External write while input full sets overrun (bit 5), keeps old word.
// R10: Outside slave mode both full flags are held clear; overrun persists.
// R11: Every finished external transfer sets the irq flag; software clears.
// R12: The interrupt reaches the CPU only while its enable bit 7 is set.
// R13: Reset loads status and control with 0000 -111; data latches undefined.
// R14: Output latch drives the data pins only while select and read are low.
// R15: Write data taken at the write strobe's rising end, after synchronising.
// R16: On parts without the port, software keeps flag and enable bits clear.
module slvp_top
	import slvp_pkg::*;
(
	input wire logic CLK_I,
	input wire logic NRST_I,
	input wire logic HSEL_I,
	input wire logic [31:0] HADDR_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic [2:0] HSIZE_I,
	input wire logic HREADY_I,
	input wire logic [31:0] HWDATA_I,
	output logic HREADYOUT_O,
	output logic HRESP_O,
	output logic [31:0] HRDATA_O,
	input wire logic [7:0] PD_I,
	output logic [7:0] PD_O,
	output logic [7:0] PD_OE_O,
	input wire logic [2:0] CP_I,
	output logic [2:0] CP_O,
	output logic [2:0] CP_OE_O,
	output logic IRQ_O
);

	slvp_state_s state_reg;
	slvp_state_s state_next;

	logic reg_wr;
	logic reg_rd;
	logic [9:0] reg_idx;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic [SYNC_W-1:0] pins_s;
	logic [7:0] data_s;
	logic rd_s;
	logic wr_s;
	logic cs_s;
	logic ext_rd_done;
	logic ext_wr_done;
	logic cpu_rd_data;
	logic cpu_wr_data;
	logic [7:0] status_ctrl;
	logic hsize_unused;

	// only whole-word transfers are issued; size needs no decode
	assign hsize_unused = ^HSIZE_I;

	// bus slave front end
	slvp_ahb u_ahb (
		.clk_i(CLK_I),
		.nrst_i(NRST_I),
		.hsel_i(HSEL_I),
		.haddr_i(HADDR_I),
		.htrans_i(HTRANS_I),
		.hwrite_i(HWRITE_I),
		.hready_i(HREADY_I),
		.hwdata_i(HWDATA_I),
		.hreadyout_o(HREADYOUT_O),
		.hresp_o(HRESP_O),
		.hrdata_o(HRDATA_O),
		.reg_wr_o(reg_wr),
		.reg_rd_o(reg_rd),
		.reg_idx_o(reg_idx),
		.reg_wdata_o(reg_wdata),
		.reg_rdata_i(reg_rdata)
	);

	// external strobes and data are asynchronous to CLK_I
	slvp_sync #(
		.W(SYNC_W),
		.RST_VAL(SYNC_RST)
	) u_sync (
		.clk_i(CLK_I),
		.nrst_i(NRST_I),
		.d_i({PD_I, CP_I}),
		.q_o(pins_s)
	); // R2 R15

	// data and strobes share one synchroniser so they stay aligned
	assign data_s = pins_s[10:3];
	assign rd_s = pins_s[PIN_RD]; // R3
	assign wr_s = pins_s[PIN_WR]; // R3
	assign cs_s = pins_s[PIN_CS]; // R3

	// a transfer ends when its strobe rises with chip select still low
	assign ext_rd_done = state_reg.mode && rd_s && !state_reg.rd_prev
		&& !state_reg.cs_prev; // R15
	assign ext_wr_done = state_reg.mode && wr_s && !state_reg.wr_prev
		&& !state_reg.cs_prev; // R15

	assign cpu_rd_data = reg_rd && (reg_idx == IDX_DATA_PORT);
	assign cpu_wr_data = reg_wr && (reg_idx == IDX_DATA_PORT);

	assign status_ctrl = {state_reg.in_full, state_reg.out_full,
		state_reg.overrun,
		state_reg.mode, 1'h0, state_reg.cp_dir};

	// register read mux; unmapped and reserved bits read as zero
	always_comb
	begin
		reg_rdata = 8'h00;
		case (reg_idx)
			IDX_DATA_PORT:
			begin
				// slave mode returns the captured input latch
				if (state_reg.mode)
					reg_rdata = state_reg.in_latch; // R5
				else
					reg_rdata = data_s;
			end
			IDX_CTRL_PINS:
				reg_rdata = {5'h00, pins_s[2:0]};
			IDX_DATA_DIR:
				reg_rdata = state_reg.d_dir;
			IDX_STATUS_CTRL:
				reg_rdata = status_ctrl;
			IDX_INT_FLAGS:
				reg_rdata = {state_reg.irq_flag, 7'h00};
			IDX_INT_ENABLES:
				reg_rdata = {state_reg.irq_en, 7'h00};
			default:
				reg_rdata = 8'h00;
		endcase
	end

	// next state: cpu writes, external events, flag upkeep
	always_comb
	begin
		state_next = state_reg;
		state_next.rd_prev = rd_s;
		state_next.wr_prev = wr_s;
		state_next.cs_prev = cs_s;

		// plain software writes
		if (reg_wr)
		begin
			case (reg_idx)
				IDX_DATA_PORT:
					state_next.out_latch = reg_wdata; // R5
				IDX_CTRL_PINS:
					state_next.cp_out = reg_wdata[2:0];
				IDX_DATA_DIR:
					state_next.d_dir = reg_wdata;
				IDX_STATUS_CTRL:
				begin
					state_next.mode = reg_wdata[BIT_MODE]; // R1
					state_next.cp_dir = reg_wdata[2:0]; // R4
					// overrun is cleared by writing zero to it
					if (!reg_wdata[BIT_OVERRUN])
						state_next.overrun = 1'h0;
				end
				IDX_INT_FLAGS:
				begin
					// write one to clear
					if (reg_wdata[BIT_IRQ])
						state_next.irq_flag = 1'h0; // R11
				end
				IDX_INT_ENABLES:
					state_next.irq_en = reg_wdata[BIT_IRQ]; // R12
				default:
					state_next.irq_en = state_reg.irq_en;
			endcase
		end

		// cpu read of the data port empties the input latch
		if (cpu_rd_data)
			state_next.in_full = 1'h0; // R7

		// cpu write fills the output latch; wins over an external read
		if (ext_rd_done)
			state_next.out_full = 1'h0; // R8
		if (cpu_wr_data)
			state_next.out_full = 1'h1; // R8

		// a read in the same cycle frees the latch for the new word
		if (ext_wr_done)
		begin
			if (state_reg.in_full && !cpu_rd_data)
				state_next.overrun = 1'h1; // R9
			else
			begin
				state_next.in_latch = data_s; // R15
				state_next.in_full = 1'h1; // R7
			end
		end

		// hardware set wins over the software clear
		if (ext_rd_done || ext_wr_done)
			state_next.irq_flag = 1'h1; // R11

		// full flags cannot stand outside slave mode; overrun is kept
		if (!state_next.mode)
		begin
			state_next.in_full = 1'h0; // R10
			state_next.out_full = 1'h0; // R10
		end
	end

	// async reset loads the documented status/control value
	always_ff @(posedge CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
			state_reg <= STATE_RST; // R13
		else
			state_reg <= state_next;
	end

	// data pins: raw strobes so an external read sees data at once
	always_comb
	begin
		if (state_reg.mode)
			PD_OE_O = {8{!CP_I[PIN_RD] && !CP_I[PIN_CS]}}; // R14 R6
		else
			PD_OE_O = ~state_reg.d_dir;
	end

	assign PD_O = state_reg.out_latch; // R14

	// control pins become inputs in slave mode regardless of directions
	assign CP_OE_O = state_reg.mode ? 3'h0 : ~state_reg.cp_dir; // R3
	assign CP_O = state_reg.cp_out;

	// one level interrupt gated by its enable
	assign IRQ_O = state_reg.irq_flag && state_reg.irq_en; // R12

endmodule

// *** slvp_top_properties.sv ***
// checker of bus timing and pin side effects of the slave port
`timescale 1ns/100ps
module slvp_chk
	import slvp_pkg::*;
(
	input wire logic CLK_I,
	input wire logic NRST_I,
	input wire logic HSEL_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic HREADY_I,
	input wire logic HREADYOUT_O,
	input wire logic [31:0] HRDATA_O,
	input wire logic [7:0] PD_O,
	input wire logic [7:0] PD_OE_O,
	input wire logic [2:0] CP_I,
	input wire logic [2:0] CP_OE_O,
	input wire logic IRQ_O
);
	logic take;
	logic rise;
	logic wr_ph_reg;
	logic rd_ph_reg;
	logic [2:0] cp_q_reg;
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!NRST_I);
	// transfer taken, and a strobe ending at the pins
	assign take = HSEL_I && HTRANS_I == HTRANS_NONSEQ && HREADY_I;
	assign rise = |(CP_I[1:0] & ~cp_q_reg[1:0]);
	// phase trackers; cleared in reset so no stale phase survives it
	always_ff @(posedge CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			wr_ph_reg <= 1'b0;
			rd_ph_reg <= 1'b0;
			cp_q_reg <= 3'h7;
		end
		else
		begin
			wr_ph_reg <= take && HWRITE_I;
			rd_ph_reg <= take && !HWRITE_I;
			cp_q_reg <= CP_I;
		end
	end
	sequence s_rd_wait;
		!HREADYOUT_O ##1 HREADYOUT_O;
	endsequence
	write_no_wait_a: assert property (take && HWRITE_I |=> HREADYOUT_O)
		else $error("write phase stalled");
	read_one_wait_a: assert property (take && !HWRITE_I |=> s_rd_wait)
		else $error("read wait wrong");
	rdata_hold_a: assert property (
		!take && !rd_ph_reg |=> $stable(HRDATA_O))
		else $error("read data moved");
	irq_rise_a: assert property (
		$rose(IRQ_O) |-> $past(wr_ph_reg) || $past(rise, 3))
		else $error("irq rose without cause");
	irq_fall_a: assert property ($fell(IRQ_O) |-> $past(wr_ph_reg))
		else $error("irq fell without write");
	pins_dir_a: assert property ($changed(CP_OE_O) |-> $past(wr_ph_reg))
		else $error("control enable moved");
	out_latch_a: assert property ($changed(PD_O) |-> $past(wr_ph_reg))
		else $error("output latch moved");
	pd_drive_a: assert property (
		$changed(PD_OE_O) |-> $changed(CP_I) || $past(wr_ph_reg))
		else $error("data drive moved");
endmodule
bind slvp_top slvp_chk i_chk (.CLK_I, .NRST_I, .HSEL_I, .HTRANS_I, .HWRITE_I,
	.HREADY_I, .HREADYOUT_O, .HRDATA_O, .PD_O, .PD_OE_O, .CP_I, .CP_OE_O, .IRQ_O);

// *** slvp_top_tb.sv ***
// self-checking bench of the parallel slave port
`timescale 1ns/100ps
module slvp_top_tb
	import slvp_pkg::*;
;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic hready, hresp, irq;
	logic [31:0] hrdata, q;
	logic [7:0] pd_in, pd_out, pd_oe, b;
	logic [2:0] cp_in, cp_oe;
	int err_total = 0;
	int num_checks = 0;
	int cyc = 0;
	always #5 clk = ~clk;
	slvp_top i_dut (.CLK_I(clk), .NRST_I(nrst), .HSEL_I(1'b1), .HADDR_I(haddr),
		.HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HREADY_I(hready),
		.HWDATA_I(hwdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
		.HRDATA_O(hrdata), .PD_I(pd_in), .PD_O(pd_out), .PD_OE_O(pd_oe),
		.CP_I(cp_in), .CP_O(), .CP_OE_O(cp_oe), .IRQ_O(irq));
	slvp_ext_proc i_ext (.clk_i(clk), .dev_pd_i(pd_out), .dev_oe_i(pd_oe),
		.pins_o(pd_in), .strobes_o(cp_in));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// single word transfer; waits are open, only the timeout ends them
	task automatic bus(input logic [9:0] idx, input logic wr,
		input logic [7:0] d);
		haddr <= {20'h0, idx, 2'h0};
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge clk); while (hready !== 1'b1);
		q = hrdata;
	endtask
	task automatic rd(input logic [9:0] idx, input logic [7:0] exp);
		bus(idx, 1'b0, 8'h00);
		chk(q, {24'h0, exp});
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// hang guard; the tests need well under a thousand cycles
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_total++;
			summarize();
		end
	end
	// main sequence
	initial
	begin
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		rd(IDX_STATUS_CTRL, STATUS_CTRL_RST);
		rd(IDX_INT_FLAGS, 8'h00);
		rd(IDX_INT_ENABLES, 8'h00);
		rd(10'h3FF, 8'h00);
		chk(irq, 1'b0);
		$display("test reset done");
		bus(IDX_STATUS_CTRL, 1'b1, 8'h17);
		bus(IDX_INT_ENABLES, 1'b1, 8'h80);
		bus(IDX_DATA_PORT, 1'b1, 8'hA5);
		rd(IDX_STATUS_CTRL, 8'h57);
		i_ext.xfer(PIN_RD, 8'h00, 3, b);
		chk(b, 8'hA5);
		chk(pd_oe, 8'h00);
		rd(IDX_STATUS_CTRL, 8'h17);
		chk(irq, 1'b1);
		bus(IDX_INT_FLAGS, 1'b1, 8'h80);
		@(posedge clk);
		chk(irq, 1'b0);
		$display("test output done");
		i_ext.xfer(PIN_WR, 8'h3C, 6, b);
		rd(IDX_STATUS_CTRL, 8'h97);
		i_ext.xfer(PIN_WR, 8'hC3, 3, b);
		rd(IDX_STATUS_CTRL, 8'hB7);
		rd(IDX_DATA_PORT, 8'h3C);
		rd(IDX_STATUS_CTRL, 8'h37);
		chk(irq, 1'b1);
		$display("test overrun done");
		bus(IDX_INT_ENABLES, 1'b1, 8'h00);
		@(posedge clk);
		chk(irq, 1'b0);
		rd(IDX_INT_FLAGS, 8'h80);
		bus(IDX_INT_FLAGS, 1'b1, 8'h80);
		i_ext.xfer(PIN_WR, 8'h5A, 3, b);
		bus(IDX_STATUS_CTRL, 1'b1, 8'h27);
		rd(IDX_STATUS_CTRL, 8'h27);
		bus(IDX_INT_FLAGS, 1'b1, 8'h80);
		i_ext.xfer(PIN_WR, 8'h11, 3, b);
		rd(IDX_STATUS_CTRL, 8'h27);
		rd(IDX_INT_FLAGS, 8'h00);
		bus(IDX_STATUS_CTRL, 1'b1, 8'h07);
		rd(IDX_STATUS_CTRL, 8'h07);
		$display("test mode exit done");
		summarize();
	end
endmodule
